/* File: src/crt_token_framer.v */
`timescale 1ns/1ps
`include "crt_token_map.vh"
module crt_token_framer (
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // serial link from the host
  input  wire        sclkPin,
  input  wire        csPin_n,
  output reg         dataOut,
  output reg         dataOutEn,
  // response-time conditions, one-cycle pulses
  input  wire        evIllegal,
  input  wire        evCmdCrc,
  input  wire        evEraseSeq,
  input  wire        evAddr,
  input  wire        evParam,
  input  wire        evEraseReset,
  // execution-time conditions, one-cycle pulses
  input  wire        evOutOfRange,
  input  wire        evCsdOverwrite,
  input  wire        evEraseParam,
  input  wire        evWpViolation,
  input  wire        evEccFail,
  input  wire        evCcError,
  input  wire        evGenError,
  input  wire        evWpEraseSkip,
  input  wire        evLockFail,
  // card state levels
  input  wire        inIdle,
  input  wire        cardLocked,
  input  wire        cardBusy,
  // token request
  input  wire        sendReq,
  input  wire [2:0]  sendKind,
  input  wire [2:0]  dataRespStatus,
  input  wire [7:0]  startByte,
  input  wire [31:0] condValue,
  input  wire [31:0] wpGroupBits,
  input  wire [5:0]  wpValidGroups,
  input  wire [11:0] dataLen,
  // data byte stream for data tokens
  input  wire [7:0]  dataByte,
  output wire        dataByteReq,
  // status
  output wire        sendBusy,
  output wire        readBoundaryCrossPermit,
  output wire        writeBoundaryCrossPermit,
  output wire [11:0] writeBlockSizeField
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam ST_BUSY = 2'h2;

  // CRC-16 (CCITT, 0x1021) one byte, MSB first
  function [15:0] crcByte;
    input [15:0] c;
    input [7:0]  b;
    integer i;
    reg [15:0] t;
    begin
      t = c;
      for (i = 7; i >= 0; i = i - 1) begin
        t = (t[15] ^ b[i]) ? ({t[14:0], 1'b0} ^ 16'h1021)
                           : {t[14:0], 1'b0};
      end
      crcByte = t;
    end
  endfunction

  // ************************************************
  // pin synchronisers and edge finding
  // ************************************************
  reg [2:0] sclkSync_q;
  reg [1:0] csSync_q;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclkSync_q <= 3'h0;
      csSync_q   <= 2'h3;
    end else begin
      sclkSync_q <= {sclkSync_q[1:0], sclkPin};
      csSync_q   <= {csSync_q[0], csPin_n};
    end
  end
  // host samples on rising edge, so we change on falling edge
  wire sclkFall = sclkSync_q[2] & ~sclkSync_q[1];
  wire csActive = ~csSync_q[1];

  // ************************************************
  // status flags
  // ************************************************
  reg [6:0] basicErr_q;
  reg [7:0] s2Err_q;
  wire clrBasic;
  wire clrS2;
  wire [6:0] basicSet;
  wire [7:0] s2Set;
  assign basicSet[`CRT_BR_IDLE]     = 1'b0;
  assign basicSet[`CRT_BR_ERASERST] = evEraseReset;
  assign basicSet[`CRT_BR_ILLEGAL]  = evIllegal;
  assign basicSet[`CRT_BR_CMDCRC]   = evCmdCrc;
  assign basicSet[`CRT_BR_ERASESEQ] = evEraseSeq;
  assign basicSet[`CRT_BR_ADDR]     = evAddr;
  assign basicSet[`CRT_BR_PARAM]    = evParam;
  assign s2Set[`CRT_S2_LOCKED]   = 1'b0;
  assign s2Set[`CRT_S2_WPSKIP]   = evWpEraseSkip | evLockFail;
  assign s2Set[`CRT_S2_ERROR]    = evGenError;
  assign s2Set[`CRT_S2_CCERR]    = evCcError;
  assign s2Set[`CRT_S2_ECCFAIL]  = evEccFail;
  assign s2Set[`CRT_S2_WPVIOL]   = evWpViolation;
  assign s2Set[`CRT_S2_ERASEPRM] = evEraseParam;
  assign s2Set[`CRT_S2_RANGE]    = evOutOfRange | evCsdOverwrite;

  // sticky; a set in the clearing cycle survives
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      basicErr_q <= 7'h00;
      s2Err_q    <= 8'h00;
    end else begin
      basicErr_q <= (basicErr_q & ~{7{clrBasic}}) | basicSet;
      s2Err_q <= (s2Err_q & ~{8{clrS2}}) | s2Set;
    end
  end
  // state indicators follow the card state, not cleared by reads
  wire [7:0] basicByte = {1'b0, basicErr_q[6:1], inIdle};
  wire [7:0] s2Byte    = {s2Err_q[7:1], cardLocked};

  // ************************************************
  // token sequencer
  // ************************************************
  reg [1:0]  state_q;
  reg [2:0]  kind_q;
  reg [7:0]  shift_q;
  reg [2:0]  bitCnt_q;
  reg [11:0] byteIdx_q;
  reg [11:0] lastIdx_q;
  reg [15:0] crc_q;
  reg [31:0] word_q;

  // write-protect payload, invalid groups forced to zero
  wire [31:0] wpMask = (wpValidGroups >= `CRT_WP_BITS) ? 32'hFFFFFFFF :
                       ((32'h1 << wpValidGroups) - 32'h1);

  // index of last byte for each kind
  reg [11:0] lastIdx;
  always @* begin
    case (sendKind)
      `CRT_K_STAT2: lastIdx = 12'h001;
      `CRT_K_COND:  lastIdx = 12'h004;
      `CRT_K_DATA: lastIdx = dataLen + 12'h002;
      `CRT_K_WPST: lastIdx = 12'h006;
      default:     lastIdx = 12'h000;
    endcase
  end

  // first byte of each token
  reg [7:0] firstByte;
  always @* begin
    case (sendKind)
      // zero, status, one in the low five bits
      `CRT_K_DRESP: firstByte = {4'h0, dataRespStatus, 1'b1};
      // error bits only; the locked state is no error
      `CRT_K_DERR:  firstByte = {4'h0, s2Byte[`CRT_S2_RANGE],
                                 s2Byte[`CRT_S2_ECCFAIL],
                                 s2Byte[`CRT_S2_CCERR],
                                 s2Byte[`CRT_S2_ERROR]};
      `CRT_K_DATA:  firstByte = startByte;
      `CRT_K_WPST:  firstByte = `CRT_TOK_START;
      default:      firstByte = basicByte;
    endcase
  end

  // next byte once the current one is out
  wire [11:0] nextIdx = byteIdx_q + 12'h001;
  wire        dataPhase = (kind_q == `CRT_K_DATA) && (nextIdx <= lastIdx_q
                          - 12'h002);
  reg [7:0] nextByte;
  always @* begin
    case (kind_q)
      `CRT_K_STAT2: nextByte = s2Byte;
      `CRT_K_COND:  nextByte = word_q[31:24];
      `CRT_K_DATA: nextByte = dataPhase ? dataByte :
                   ((nextIdx == lastIdx_q) ? crc_q[7:0] : crc_q[15:8]);
      `CRT_K_WPST: nextByte = (nextIdx <= 12'h004) ? word_q[31:24] :
                   ((nextIdx == lastIdx_q) ? crc_q[7:0] : crc_q[15:8]);
      default:     nextByte = `CRT_IDLE_BYTE;
    endcase
  end
  // crc covers the payload only, not the start byte
  wire crcFeed = (kind_q == `CRT_K_DATA) ? dataPhase :
                 ((kind_q == `CRT_K_WPST) && (nextIdx <= 12'h004));

  wire byteDone = sclkFall && (bitCnt_q == 3'h7);
  assign dataByteReq = (state_q == ST_SEND) && byteDone && dataPhase;
  assign sendBusy    = (state_q != ST_IDLE);
  wire busyKind = (kind_q == `CRT_K_BUSYX) || (kind_q == `CRT_K_DRESP);
  // flags clear in the edge that copies them into the shifter, so a
  // flag set in that same edge is kept for the next report
  wire takeNow   = csActive && (state_q == ST_IDLE) && sendReq;
  wire stat2Load = csActive && (state_q == ST_SEND) && byteDone &&
                   (kind_q == `CRT_K_STAT2) && (byteIdx_q == 12'h000);
  assign clrBasic = takeNow && (sendKind <= `CRT_K_COND);
  assign clrS2    = stat2Load || (takeNow && (sendKind == `CRT_K_DERR));

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= ST_IDLE;
      kind_q    <= `CRT_K_BASIC;
      shift_q   <= `CRT_IDLE_BYTE;
      bitCnt_q  <= 3'h0;
      byteIdx_q <= 12'h000;
      lastIdx_q <= 12'h000;
      crc_q     <= 16'h0000;
      word_q    <= 32'h00000000;
    end else begin
      if (!csActive) begin
        // deselect aborts; host owns framing
        state_q  <= ST_IDLE;
        shift_q  <= `CRT_IDLE_BYTE;
        bitCnt_q <= 3'h0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (sendReq) begin
              kind_q    <= sendKind;
              shift_q   <= firstByte;
              bitCnt_q  <= 3'h0;
              byteIdx_q <= 12'h000;
              lastIdx_q <= lastIdx;
              crc_q     <= 16'h0000;
              word_q    <= (sendKind == `CRT_K_WPST) ?
                           (wpGroupBits & wpMask) : condValue;
              state_q   <= ST_SEND;
            end
          end
          ST_SEND: begin
            if (sclkFall) begin
              bitCnt_q <= bitCnt_q + 3'h1;
              shift_q  <= {shift_q[6:0], 1'b1};
              if (byteDone) begin
                if (byteIdx_q == lastIdx_q) begin
                  // only a busy-capable token may hold the line low
                  shift_q <= (busyKind && cardBusy) ? `CRT_BUSY_BYTE
                                                    : `CRT_READY_BYTE;
                  state_q <= (busyKind && cardBusy) ? ST_BUSY
                                                    : ST_IDLE;
                end else begin
                  byteIdx_q <= nextIdx;
                  shift_q   <= nextByte;
                  if (crcFeed)
                    crc_q <= crcByte(crc_q, nextByte);
                  if (kind_q == `CRT_K_COND || kind_q == `CRT_K_WPST)
                    word_q <= {word_q[23:0], 8'h00};
                end
              end
            end
          end
          ST_BUSY: begin
            // zero bytes while busy, first nonzero byte ends it
            if (sclkFall) begin
              // count wraps so busy bytes stay byte aligned
              bitCnt_q <= bitCnt_q + 3'h1;
              shift_q  <= {shift_q[6:0], 1'b1};
              if (byteDone) begin
                shift_q <= cardBusy ? `CRT_BUSY_BYTE : `CRT_READY_BYTE;
                if (!cardBusy)
                  state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // output pin: msb of the shifter, driven while selected
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut   <= 1'b1;
      dataOutEn <= 1'b0;
    end else begin
      dataOut   <= shift_q[7];
      dataOutEn <= csActive;
    end
  end

  // fixed card properties
  assign writeBlockSizeField      = `CRT_WR_BLOCK_LEN;
  assign readBoundaryCrossPermit  = `CRT_MISALIGN_OK;
  assign writeBoundaryCrossPermit = `CRT_MISALIGN_OK;

endmodule // crt_token_framer

/* File: src/crt_token_map.vh */
`ifndef CRT_TOKEN_MAP_VH
`define CRT_TOKEN_MAP_VH
// basic response bit positions
`define CRT_BR_IDLE      0
`define CRT_BR_ERASERST  1
`define CRT_BR_ILLEGAL   2
`define CRT_BR_CMDCRC    3
`define CRT_BR_ERASESEQ  4
`define CRT_BR_ADDR      5
`define CRT_BR_PARAM     6
// second status byte bit positions
`define CRT_S2_LOCKED    0
`define CRT_S2_WPSKIP    1
`define CRT_S2_ERROR     2
`define CRT_S2_CCERR     3
`define CRT_S2_ECCFAIL   4
`define CRT_S2_WPVIOL    5
`define CRT_S2_ERASEPRM  6
`define CRT_S2_RANGE     7
// tokens
`define CRT_TOK_START    8'hFE
`define CRT_TOK_MWSTART  8'hFC
`define CRT_TOK_STOP     8'hFD
`define CRT_DR_ACCEPT    3'h2
`define CRT_DR_CRCREJ    3'h5
`define CRT_DR_WRREJ     3'h6
`define CRT_BUSY_BYTE    8'h00
`define CRT_READY_BYTE   8'hFF
`define CRT_IDLE_BYTE    8'hFF
// sizes
`define CRT_WR_BLOCK_LEN 12'h200
`define CRT_MAX_BLOCK    12'h800
`define CRT_WP_BITS      6'h20
`define CRT_MISALIGN_OK  1'b0
// kinds of token to send
`define CRT_K_BASIC 3'h0
`define CRT_K_BUSYX 3'h1
`define CRT_K_STAT2 3'h2
`define CRT_K_COND  3'h3
`define CRT_K_DRESP 3'h4
`define CRT_K_DERR  3'h5
`define CRT_K_DATA  3'h6
`define CRT_K_WPST  3'h7
`endif

/* File: verification/crt_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// spi host model
// ****************************************
module crt_host_model (
  // serial link
  output logic sclkPin,
  output logic csPin_n,
  input  wire  dataOut
);
  initial begin
    sclkPin = 1'b0;
    csPin_n = 1'b1;
  end
  // clock idles low; sample late in high phase, clear of the shift
  task automatic shift_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #160 sclkPin = 1'b1;
      #159 b[i] = dataOut;
      #1 sclkPin = 1'b0;
    end
  endtask
endmodule // crt_host_model

/* File: verification/crt_token_framer_assertions.sv */
`timescale 1ns/1ps
// ****************************************
// framer port checker
// ****************************************
module crt_token_framer_assertions (
  // clock and reset
  input wire        mclk,
  input wire        reset_n,
  // link and request
  input wire        sclkPin,
  input wire        dataOut,
  input wire        dataOutEn,
  input wire        sendReq,
  input wire [2:0]  sendKind,
  input wire        dataByteReq,
  input wire        sendBusy,
  // constant status
  input wire        readBoundaryCrossPermit,
  input wire        writeBoundaryCrossPermit,
  input wire [11:0] writeBlockSizeField
);
  logic       sclkSeen_q;
  logic [3:0] sinceFall_q;
  wire        take = sendReq && !sendBusy && dataOutEn;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // age of last pin fall, saturating so long idles never wrap
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclkSeen_q  <= 1'b0;
      sinceFall_q <= 4'hF;
    end else begin
      sclkSeen_q <= sclkPin;
      if (sclkSeen_q && !sclkPin)
        sinceFall_q <= 4'h0;
      else if (sinceFall_q != 4'hF)
        sinceFall_q <= sinceFall_q + 4'h1;
    end
  end
  permit_zero_a:
    assert property (!readBoundaryCrossPermit && !writeBoundaryCrossPermit)
    else $error("boundary permit set");
  block_size_a:
    assert property (writeBlockSizeField == 12'h200)
    else $error("write block size not 512");
  basic_top_a:
    assert property (take && sendKind <= 3'h1 |=> sendBusy ##1 !dataOut)
    else $error("basic byte top bit not zero");
  status_top_a:
    assert property (take && sendKind == 3'h2 |-> ##2 !dataOut)
    else $error("status first byte top bit set");
  cond_top_a:
    assert property (take && sendKind == 3'h3 |-> ##2 !dataOut)
    else $error("conditions first byte top bit set");
  start_top_a:
    assert property (take && sendKind[2:1] == 2'b11 |-> ##2 dataOut)
    else $error("start byte top bit clear");
  shift_edge_a:
    assert property ($changed(dataOut) && $past(sendBusy, 2)
      |-> sinceFall_q inside {[4'h2:4'h5]})
    else $error("serial bit moved without clock fall");
  byte_req_a:
    assert property (dataByteReq |-> sendBusy)
    else $error("byte request outside token");
  busy_cause_a:
    assert property ($rose(sendBusy) |-> $past(sendReq) && $past(dataOutEn))
    else $error("token started without request");
endmodule // crt_token_framer_assertions

/* File: verification/crt_token_framer_tb.sv */
`timescale 1ns/1ps
// ****************************************
// framer bench
// ****************************************
module crt_token_framer_tb;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [14:0] ev = 15'h0000;
  logic        inIdle = 1'b0;
  logic        cardLocked = 1'b0;
  logic        cardBusy = 1'b0;
  logic        sendReq = 1'b0;
  logic [2:0]  sendKind = 3'h0;
  logic [2:0]  drs = 3'h2;
  logic [7:0]  startByte = 8'hFE;
  logic [31:0] condValue = 32'h0;
  logic [31:0] wpBits = 32'h0;
  logic [5:0]  wpValid = 6'h00;
  logic [11:0] dataLen = 12'h001;
  logic [7:0]  dataByte = 8'h00;
  logic [14:0] sticky = 15'h0000;
  logic [7:0]  dq [0:512];
  logic [7:0]  b;
  logic [2:0]  rs [3] = '{3'h2, 3'h5, 3'h6};
  logic [7:0]  sb [3] = '{8'hFE, 8'hFC, 8'hFD};
  int          ei [4] = '{6, 10, 11, 12};
  wire         sclkPin, csPin_n, dataOut, dataOutEn, dataByteReq, sendBusy;
  wire         rdPermit, wrPermit;
  wire  [11:0] blkSize;
  int          nErrors = 0, samplesChecked = 0, cycles = 0, di = 0;
  crt_token_framer crt_token_framer_inst (.mclk(mclk), .reset_n(reset_n),
    .sclkPin(sclkPin), .csPin_n(csPin_n), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .evIllegal(ev[0]), .evCmdCrc(ev[1]),
    .evEraseSeq(ev[2]), .evAddr(ev[3]), .evParam(ev[4]),
    .evEraseReset(ev[5]), .evOutOfRange(ev[6]), .evCsdOverwrite(ev[7]),
    .evEraseParam(ev[8]), .evWpViolation(ev[9]), .evEccFail(ev[10]),
    .evCcError(ev[11]), .evGenError(ev[12]), .evWpEraseSkip(ev[13]),
    .evLockFail(ev[14]), .inIdle(inIdle), .cardLocked(cardLocked),
    .cardBusy(cardBusy), .sendReq(sendReq), .sendKind(sendKind),
    .dataRespStatus(drs), .startByte(startByte), .condValue(condValue),
    .wpGroupBits(wpBits), .wpValidGroups(wpValid), .dataLen(dataLen),
    .dataByte(dataByte), .dataByteReq(dataByteReq), .sendBusy(sendBusy),
    .readBoundaryCrossPermit(rdPermit), .writeBoundaryCrossPermit(wrPermit),
    .writeBlockSizeField(blkSize));
  crt_host_model crt_host_model_inst (.sclkPin(sclkPin), .csPin_n(csPin_n),
    .dataOut(dataOut));
  always #20 mclk = ~mclk;
  // hang guard, well above the longest token sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      nErrors++;
      finish_test();
    end
  end
  // payload feed, next byte offered once the request edge has passed
  always @(posedge mclk)
    if (dataByteReq) begin
      #2 di++;
      dataByte = dq[di];
    end
  function automatic logic [7:0] expR1(logic [14:0] e);
    return {1'b0, e[4], e[3], e[2], e[1], e[0], e[5], inIdle};
  endfunction
  function automatic logic [7:0] expS2(logic [14:0] e);
    return {e[6] | e[7], e[8], e[9], e[10], e[11], e[12], e[13] | e[14],
      cardLocked};
  endfunction
  function automatic logic [15:0] crc16(logic [15:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic finish_test();
    if (nErrors == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask
  task automatic rd();
    crt_host_model_inst.shift_byte(b);
  endtask
  task automatic expect8(string name, logic [7:0] e);
    rd();
    check(name, 16'(b), 16'(e));
  endtask
  task automatic send(logic [2:0] k);
    sendKind = k;
    sendReq = 1'b1;
    tick();
    sendReq = 1'b0;
  endtask
  task automatic pulse(logic [14:0] e);
    ev = e;
    tick();
    ev = 15'h0000;
    sticky |= e;
  endtask
  // host keeps clocking, at most 16 bytes, while the token or busy phase lasts
  task automatic drain();
    int g = 0;
    repeat (8) tick();
    while (sendBusy === 1'b1 && g < 16) begin
      rd();
      g++;
      repeat (8) tick();
    end
    check("busy end", 16'(sendBusy), 16'h0000);
  endtask
  task automatic exp_block(int n);
    logic [15:0] c = 16'h0000;
    for (int i = 0; i < n; i++) begin
      expect8("payload", dq[i]);
      c = crc16(c, dq[i]);
    end
    expect8("crc hi", c[15:8]);
    expect8("crc lo", c[7:0]);
  endtask
  initial begin
    void'($urandom(89870));
    repeat (6) @(posedge mclk);
    #2 reset_n = 1'b1;
    check("permits", 16'({rdPermit, wrPermit}), 16'h0000);
    check("block size", 16'(blkSize), 16'h0200);
    crt_host_model_inst.csPin_n = 1'b0;
    repeat (8) tick();
    check("drive en", 16'(dataOutEn), 16'h0001);
    // busy-extended answer, busy released in mid-phase
    cardBusy = 1'b1;
    send(3'h1);
    expect8("busy basic", expR1(sticky));
    expect8("busy 0", 8'h00);
    expect8("busy 1", 8'h00);
    tick();
    cardBusy = 1'b0;
    for (int i = 0; i < 4 && b == 8'h00; i++)
      rd();
    check("ready", 16'(b != 8'h00), 16'h0001);
    drain();
    for (int i = 0; i < 3; i++) begin
      drs = rs[i];
      send(3'h4);
      rd();
      check("data resp", 16'(b), 16'({4'h0, rs[i], 1'b1}));
      drain();
    end
    for (int i = 0; i < 4; i++) begin
      logic [3:0] et;
      pulse(15'h0001 << ei[i]);
      send(3'h5);
      rd();
      // range, ecc, controller, general error in the low nibble
      et = {sticky[6] | sticky[7], sticky[10], sticky[11], sticky[12]};
      check("err tok", 16'(b), 16'(et));
      sticky[14:6] = 9'h000;
      drain();
    end
    // random flags; expected sticky copy clears as each byte reports
    for (int i = 0; i < 12; i++) begin
      logic [2:0] k;
      k = (i % 3 == 0) ? 3'h0 : (i % 3 == 1) ? 3'h2 : 3'h3;
      inIdle = 1'($urandom);
      cardLocked = 1'($urandom);
      condValue = $urandom;
      pulse(15'($urandom));
      send(k);
      expect8("basic", expR1(sticky));
      if (k == 3'h2)
        expect8("status", expS2(sticky));
      for (int j = 3; k == 3'h3 && j >= 0; j--)
        expect8("cond", condValue[8*j+:8]);
      sticky[5:0] = 6'h00;
      if (k == 3'h2)
        sticky[14:6] = 9'h000;
      drain();
    end
    for (int j = 0; j < 3; j++) begin
      startByte = sb[j];
      dataLen = (j == 0) ? 12'h200 : 12'($urandom_range(1, 8));
      for (int i = 0; i <= 512; i++)
        dq[i] = 8'($urandom);
      di = 0;
      dataByte = dq[0];
      send(3'h6);
      expect8("start", sb[j]);
      if (j < 2)
        exp_block(int'(dataLen));
      drain();
    end
    for (int j = 0; j < 3; j++) begin
      logic [31:0] m;
      wpBits = $urandom;
      wpValid = (j == 0) ? 6'h00 : (j == 1) ? 6'h20 : 6'($urandom_range(1, 31));
      m = (wpValid >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << wpValid) - 32'h1;
      {dq[0], dq[1], dq[2], dq[3]} = wpBits & m;
      send(3'h7);
      expect8("wp start", 8'hFE);
      exp_block(4);
      drain();
    end
    finish_test();
  end
endmodule // crt_token_framer_tb
bind crt_token_framer crt_token_framer_assertions
  crt_token_framer_assertions_inst (.mclk(mclk), .reset_n(reset_n),
  .sclkPin(sclkPin), .dataOut(dataOut), .dataOutEn(dataOutEn),
  .sendReq(sendReq), .sendKind(sendKind), .dataByteReq(dataByteReq),
  .sendBusy(sendBusy), .readBoundaryCrossPermit(readBoundaryCrossPermit),
  .writeBoundaryCrossPermit(writeBoundaryCrossPermit),
  .writeBlockSizeField(writeBlockSizeField));
